/* File: hw/srap_ctrl.sv */
// Mainframe-side controller driving one breadboard card slot bus
`timescale 1ns/100ps
// Contract
// - Initialize command pulses digital reset line
// - Reset also pulses digital reset line
// - Read returns one byte from register
// - Write delivers one byte to register
// - Select exactly the addressed slot during transfer
// - Register number binary on address lines
// - Read strobe asserted during read command
// - Write strobe with valid data lines
// - Shared data lines are multi-drop
module srap_ctrl
  import srap_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire srap_cmd_t CMD,
  output logic RSP_VALID,
  output srap_rsp_t RSP,
  output logic [NUM_SLOTS-1:0] SLOT_SEL,
  output logic REG_ADDR_BIT2,
  output logic REG_ADDR_BIT1,
  output logic REG_ADDR_BIT0,
  output logic RD_STROBE,
  output logic WR_STROBE,
  input wire logic [DATA_W-1:0] SHARED_DATA_LINES_I,
  output logic [DATA_W-1:0] SHARED_DATA_LINES_O,
  output logic SHARED_DATA_LINES_OE,
  output logic DIG_RESET
);

  // ----------------------------------------------------------------
  // State and registers
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RESET} srap_state_t;

  srap_state_t state_q;
  srap_state_t state_d;
  logic [NUM_SLOTS-1:0] sel_q;
  logic [NUM_SLOTS-1:0] sel_d;
  logic [REG_W-1:0] addr_q;
  logic [REG_W-1:0] addr_d;
  logic is_read_q;
  logic is_read_d;
  logic rd_q;
  logic rd_d;
  logic wr_q;
  logic wr_d;
  logic oe_q;
  logic oe_d;
  logic [DATA_W-1:0] wdata_q;
  logic [DATA_W-1:0] wdata_d;
  logic rst_line_q;
  logic rst_line_d;
  logic rsp_valid_q;
  logic rsp_valid_d;
  srap_rsp_t rsp_q;
  srap_rsp_t rsp_d;
  logic tmr_load;
  logic [TMR_W-1:0] tmr_count;
  logic tmr_done;

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  wire accept = CMD_VALID && (state_q == ST_IDLE);
  wire slot_ok = (CMD.slot <= LAST_SLOT);
  wire is_xfer = (CMD.op == SRAP_OP_READ) || (CMD.op == SRAP_OP_WRITE);
  wire start_xfer = accept && is_xfer && slot_ok;
  wire start_init = accept && (CMD.op == SRAP_OP_INIT);
  // Out-of-range slot is refused without touching the backplane
  wire bad_slot = accept && is_xfer && !slot_ok;
  wire [NUM_SLOTS-1:0] slot_onehot = {{(NUM_SLOTS-1){1'b0}}, 1'b1} << CMD.slot;

  assign CMD_READY = (state_q == ST_IDLE);

  srap_timer #(
    .INIT_COUNT(TMR_W'(DIG_RESET_CYC))
  ) u_timer (
    .CORE_CLK(CORE_CLK),
    .RST(RST),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    sel_d = sel_q;
    addr_d = addr_q;
    is_read_d = is_read_q;
    rd_d = rd_q;
    wr_d = wr_q;
    oe_d = oe_q;
    wdata_d = wdata_q;
    rst_line_d = rst_line_q;
    rsp_valid_d = 1'b0;
    rsp_d = rsp_q;
    tmr_load = 1'b0;
    tmr_count = TMR_W'(SETUP_CYC);
    unique case (state_q)
      ST_IDLE: begin
        if (start_xfer) begin
          // Select and address settle before any strobe
          sel_d = slot_onehot;
          addr_d = CMD.regn;
          is_read_d = (CMD.op == SRAP_OP_READ);
          // Data driven only on writes; released while the card answers reads
          oe_d = (CMD.op == SRAP_OP_WRITE);
          wdata_d = CMD.data;
          tmr_load = 1'b1;
          state_d = ST_SETUP;
        end else if (start_init) begin
          rst_line_d = 1'b1;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(DIG_RESET_CYC);
          state_d = ST_RESET;
        end else if (bad_slot) begin
          rsp_valid_d = 1'b1;
          rsp_d = '{err: 1'b1, data: 8'h00};
        end else if (accept) begin
          // Other commands get an empty answer and no bus activity
          rsp_valid_d = 1'b1;
          rsp_d = '{err: 1'b0, data: 8'h00};
        end
      end
      ST_SETUP: begin
        if (tmr_done) begin
          rd_d = is_read_q;
          wr_d = !is_read_q;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(STROBE_CYC);
          state_d = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (tmr_done) begin
          // Sampled at strobe end, well past the card's access time
          if (is_read_q) begin
            rsp_d = '{err: 1'b0, data: SHARED_DATA_LINES_I};
          end else begin
            rsp_d = '{err: 1'b0, data: 8'h00};
          end
          rd_d = 1'b0;
          wr_d = 1'b0;
          tmr_load = 1'b1;
          tmr_count = TMR_W'(HOLD_CYC);
          state_d = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (tmr_done) begin
          sel_d = '0;
          oe_d = 1'b0;
          rsp_valid_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_RESET: begin
        if (tmr_done) begin
          rst_line_d = 1'b0;
          rsp_valid_d = 1'b1;
          rsp_d = '{err: 1'b0, data: 8'h00};
          state_d = ST_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      // Reset leaves the card's digital reset pulsing for a full period
      state_q <= ST_RESET;
      rst_line_q <= 1'b1;
      sel_q <= '0;
      addr_q <= 3'h0;
      is_read_q <= 1'b0;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      oe_q <= 1'b0;
      wdata_q <= 8'h00;
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end else begin
      state_q <= state_d;
      rst_line_q <= rst_line_d;
      sel_q <= sel_d;
      addr_q <= addr_d;
      is_read_q <= is_read_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      oe_q <= oe_d;
      wdata_q <= wdata_d;
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
    end
  end

  assign SLOT_SEL = sel_q;
  assign {REG_ADDR_BIT2, REG_ADDR_BIT1, REG_ADDR_BIT0} = addr_q;
  assign RD_STROBE = rd_q;
  assign WR_STROBE = wr_q;
  assign SHARED_DATA_LINES_O = wdata_q;
  assign SHARED_DATA_LINES_OE = oe_q;
  assign DIG_RESET = rst_line_q;
  assign RSP_VALID = rsp_valid_q;
  assign RSP = rsp_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [TMR_W-1:0] strb_cnt_q;
  logic [TMR_W-1:0] rst_cnt_q;

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      strb_cnt_q <= 8'h00;
      rst_cnt_q <= 8'h00;
    end else begin
      strb_cnt_q <= (rd_q || wr_q) ? strb_cnt_q + 8'h01 : 8'h00;
      rst_cnt_q <= rst_line_q ? rst_cnt_q + 8'h01 : 8'h00;
    end
  end

  sequence s_xfer_start;
    CMD_VALID && CMD_READY && is_xfer && slot_ok;
  endsequence

  sequence s_strobe_on;
    $rose(RD_STROBE || WR_STROBE);
  endsequence

  property p_init_reset;
    @(posedge CORE_CLK) disable iff (RST)
    (CMD_VALID && CMD_READY && CMD.op == SRAP_OP_INIT) |=> DIG_RESET [*8];
  endproperty
  a_init_reset: assert property (p_init_reset) else $error("Init did not raise digital reset");

  property p_reset_len;
    @(posedge CORE_CLK) disable iff (RST)
    $fell(DIG_RESET) |-> rst_cnt_q == TMR_W'(DIG_RESET_CYC);
  endproperty
  a_reset_len: assert property (p_reset_len) else $error("Digital reset pulse length wrong");

  property p_read_data;
    @(posedge CORE_CLK) disable iff (RST)
    $fell(RD_STROBE) |-> RSP.data == $past(SHARED_DATA_LINES_I) ##[1:10] RSP_VALID;
  endproperty
  a_read_data: assert property (p_read_data) else $error("Read byte not returned");

  property p_write_seq;
    @(posedge CORE_CLK) disable iff (RST)
    (s_xfer_start and CMD.op == SRAP_OP_WRITE) ##1 1'b1 |-> ##[19:21] WR_STROBE && SHARED_DATA_LINES_OE;
  endproperty
  a_write_seq: assert property (p_write_seq) else $error("Write strobe not on time");

  property p_sel_onehot;
    @(posedge CORE_CLK) disable iff (RST)
    (RD_STROBE || WR_STROBE) |-> $onehot(SLOT_SEL) && $stable(SLOT_SEL);
  endproperty
  a_sel_onehot: assert property (p_sel_onehot) else $error("Slot select not single during strobe");

  property p_addr_setup;
    @(posedge CORE_CLK) disable iff (RST)
    s_strobe_on |-> $past(SLOT_SEL, SETUP_CYC) == SLOT_SEL && $onehot(SLOT_SEL);
  endproperty
  a_addr_setup: assert property (p_addr_setup) else $error("Select not set up before strobe");

  property p_strobe_width;
    @(posedge CORE_CLK) disable iff (RST)
    $fell(RD_STROBE || WR_STROBE) |-> strb_cnt_q == TMR_W'(STROBE_CYC) ##[6:6] SLOT_SEL == '0;
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("Strobe width or hold wrong");

  property p_wr_drive;
    @(posedge CORE_CLK) disable iff (RST)
    WR_STROBE |-> SHARED_DATA_LINES_OE && $stable(SHARED_DATA_LINES_O);
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("Write data not driven");

  property p_rd_release;
    @(posedge CORE_CLK) disable iff (RST)
    (RD_STROBE || (SLOT_SEL == '0)) |-> !SHARED_DATA_LINES_OE;
  endproperty
  a_rd_release: assert property (p_rd_release) else $error("Data lines driven during read");

endmodule

/* File: hw/srap_pkg.sv */
// Shared constants and types for the slot register access controller
package srap_pkg;

  // ----------------------------------------------------------------
  // Backplane geometry
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 90;
  localparam int SLOT_W = 7;
  localparam int REG_W = 3;
  localparam int DATA_W = 8;
  localparam logic [SLOT_W-1:0] LAST_SLOT = 7'h59;

  // ----------------------------------------------------------------
  // Timing in ns and derived cycle counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_ADDR_SETUP_NS = 100;
  localparam int T_STROBE_NS = 450;
  localparam int T_ADDR_HOLD_NS = 30;
  localparam int T_DIG_RESET_NS = 500;
  localparam int SETUP_CYC = (T_ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_CYC = (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (T_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DIG_RESET_CYC = (T_DIG_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

  // ----------------------------------------------------------------
  // Command and response carriers
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    SRAP_OP_NOP,
    SRAP_OP_INIT,
    SRAP_OP_READ,
    SRAP_OP_WRITE
  } srap_op_t;

  typedef struct packed {
    srap_op_t op;
    logic [SLOT_W-1:0] slot;
    logic [REG_W-1:0] regn;
    logic [DATA_W-1:0] data;
  } srap_cmd_t;

  typedef struct packed {
    logic err;
    logic [DATA_W-1:0] data;
  } srap_rsp_t;

endpackage

/* File: hw/srap_timer.sv */
// Down-counting phase timer used to pace backplane transfer phases
`timescale 1ns/100ps
module srap_timer
  import srap_pkg::*;
#(
  parameter logic [TMR_W-1:0] INIT_COUNT = 8'h00
) (
  input wire logic CORE_CLK,
  input wire logic RST,
  input wire logic load,
  input wire logic [TMR_W-1:0] count,
  output logic done
);

  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  // Done in the last cycle of a phase of exactly count cycles
  assign done = (cnt_q == 8'h01);
  assign cnt_d = load ? count : ((cnt_q != 8'h00) ? cnt_q - 8'h01 : cnt_q);

  always_ff @(posedge CORE_CLK or posedge RST) begin
    if (RST) begin
      cnt_q <= INIT_COUNT;
    end else begin
      cnt_q <= cnt_d;
    end
  end

endmodule

/* File: verification/srap_card_model.sv */
// Behavioural breadboard card answering on one backplane slot
`timescale 1ns/100ps
module srap_card_model
  import srap_pkg::*;
#(
  parameter int CARD_SLOT = 2
) (
  input wire logic [NUM_SLOTS-1:0] slot_sel,
  input wire logic [REG_W-1:0] reg_addr,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic dig_reset,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  output logic [7:0] rd_lines,
  output logic [7:0] wt_lines
);
  // ----------------------------------------------------------------
  // Card registers and decoders
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] regs_q [8];
  logic sel;
  assign sel = slot_sel[CARD_SLOT];
  assign rd_lines = (sel && rd_strobe) ? (8'h01 << reg_addr) : 8'h00;
  assign wt_lines = (sel && wr_strobe) ? (8'h01 << reg_addr) : 8'h00;
  // Drive only while selected and read, so other cards can share the bus
  assign data_oe = sel && rd_strobe;
  assign data_out = regs_q[reg_addr];
  // No identifying reply exists, so nothing else reaches the registers
  always @(posedge dig_reset or negedge wr_strobe) begin
    if (dig_reset) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= 8'h00;
      end
    end else if (sel) begin
      regs_q[reg_addr] <= data_in;
    end
  end
endmodule

/* File: verification/tb_top.sv */
// Self-checking bench for the slot register access controller
`timescale 1ns/100ps
module tb_top;
  import srap_pkg::*;
  logic CORE_CLK, RST, CMD_VALID, CMD_READY, RSP_VALID, RD_STROBE, WR_STROBE, DIG_RESET, ctrl_oe, card_oe;
  logic REG_ADDR_BIT2, REG_ADDR_BIT1, REG_ADDR_BIT0;
  logic [NUM_SLOTS-1:0] SLOT_SEL;
  logic [7:0] bus, ctrl_o, card_d, last_q, rd_lines, wt_lines, seen_rd, seen_wt;
  srap_cmd_t CMD;
  srap_rsp_t RSP, rsp_q;
  int error_cnt, compares, cyc, lat, rst_cyc, strb_cyc;
  localparam int RW_LAT = 1 + SETUP_CYC + STROBE_CYC + HOLD_CYC;

  srap_ctrl dut_u (.CORE_CLK(CORE_CLK), .RST(RST), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD),
    .RSP_VALID(RSP_VALID), .RSP(RSP), .SLOT_SEL(SLOT_SEL), .REG_ADDR_BIT2(REG_ADDR_BIT2),
    .REG_ADDR_BIT1(REG_ADDR_BIT1), .REG_ADDR_BIT0(REG_ADDR_BIT0), .RD_STROBE(RD_STROBE), .WR_STROBE(WR_STROBE),
    .SHARED_DATA_LINES_I(bus), .SHARED_DATA_LINES_O(ctrl_o), .SHARED_DATA_LINES_OE(ctrl_oe),
    .DIG_RESET(DIG_RESET));
  srap_card_model #(.CARD_SLOT(2)) card_u (.slot_sel(SLOT_SEL), .reg_addr({REG_ADDR_BIT2, REG_ADDR_BIT1, REG_ADDR_BIT0}),
    .rd_strobe(RD_STROBE), .wr_strobe(WR_STROBE), .dig_reset(DIG_RESET), .data_in(bus), .data_out(card_d),
    .data_oe(card_oe), .rd_lines(rd_lines), .wt_lines(wt_lines));

  // Undriven bus shows a changing pattern so stale data never looks valid
  assign bus = card_oe ? card_d : (ctrl_oe ? ctrl_o : ~last_q);
  always @(posedge CORE_CLK) last_q <= bus;

  initial begin
    CORE_CLK = 1'b0;
    forever #2.5 CORE_CLK = ~CORE_CLK;
  end
  always @(posedge CORE_CLK) begin
    cyc++;
    if (cyc == 10000) begin
      error_cnt++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic do_cmd(input srap_op_t op, input logic [6:0] s, input logic [2:0] r, input logic [7:0] d);
    {lat, rst_cyc, strb_cyc, seen_rd, seen_wt} = '0;
    while (CMD_READY !== 1'b1) begin
      @(posedge CORE_CLK);
      #1;
    end
    CMD = '{op, s, r, d};
    CMD_VALID = 1'b1;
    @(posedge CORE_CLK);
    #1;
    CMD_VALID = 1'b0;
    // The take edge counts as the first cycle; outputs launched there are sampled too
    lat = 1;
    forever begin
      seen_rd |= rd_lines;
      seen_wt |= wt_lines;
      rst_cyc += int'(DIG_RESET === 1'b1);
      strb_cyc += int'(RD_STROBE === 1'b1 || WR_STROBE === 1'b1);
      if (RSP_VALID === 1'b1 || lat >= 300) begin
        break;
      end
      @(posedge CORE_CLK);
      #1;
      lat++;
    end
    if (RSP_VALID !== 1'b1) begin
      error_cnt++;
      $display("mismatch rsp_valid expected 1 seen 0");
    end
    rsp_q = RSP;
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    repeat (3) @(posedge CORE_CLK);
    #1;
    check("reset_line_in_rst", 16'h1, {15'h0, DIG_RESET});
    RST = 1'b0;
    while (RSP_VALID !== 1'b1 && cyc < 500) begin
      @(posedge CORE_CLK);
      #1;
    end
    check("reset_line_after", 16'h0, {15'h0, DIG_RESET});
  endtask

  task automatic t_wr_rd();
    for (int r = 0; r < 8; r++) begin
      do_cmd(SRAP_OP_WRITE, 7'h02, r[2:0], {r[2:0], 2'b01, r[2:0]});
      check("wr_latency", RW_LAT[15:0], lat[15:0]);
      check("wr_strobe_len", STROBE_CYC[15:0], strb_cyc[15:0]);
      check("wt_decode", {8'h00, 8'h01 << r}, {8'h00, seen_wt});
    end
    for (int r = 0; r < 8; r++) begin
      do_cmd(SRAP_OP_READ, 7'h02, r[2:0], 8'h00);
      check("rd_data", {8'h00, r[2:0], 2'b01, r[2:0]}, {7'h00, rsp_q});
      check("rd_decode", {8'h00, 8'h01 << r}, {8'h00, seen_rd});
    end
  endtask

  task automatic t_other_slot();
    do_cmd(SRAP_OP_WRITE, 7'h03, 3'h0, 8'hff);
    check("foreign_wt", 16'h0, {8'h00, seen_wt});
    do_cmd(SRAP_OP_READ, 7'h02, 3'h0, 8'h00);
    check("untouched", 16'h0008, {7'h00, rsp_q});
    do_cmd(SRAP_OP_READ, LAST_SLOT, 3'h7, 8'h00);
    check("last_slot_lat", RW_LAT[15:0], lat[15:0]);
    check("last_slot_err", 16'h0, {15'h0, rsp_q.err});
  endtask

  task automatic t_refused();
    do_cmd(SRAP_OP_NOP, 7'h02, 3'h1, 8'h00);
    check("nop_lat", 16'h1, lat[15:0]);
    check("nop_err", 16'h0, {15'h0, rsp_q.err});
    do_cmd(SRAP_OP_WRITE, 7'h5a, 3'h1, 8'h00);
    check("bad_slot_err", 16'h1, {15'h0, rsp_q.err});
    check("bad_slot_strobe", 16'h0, strb_cyc[15:0]);
  endtask

  task automatic t_init();
    do_cmd(SRAP_OP_INIT, 7'h00, 3'h0, 8'h00);
    check("init_lat", DIG_RESET_CYC[15:0] + 16'h1, lat[15:0]);
    check("init_pulse", DIG_RESET_CYC[15:0], rst_cyc[15:0]);
    do_cmd(SRAP_OP_READ, 7'h02, 3'h5, 8'h00);
    check("cleared_reg", 16'h0, {7'h00, rsp_q});
  endtask

  initial begin
    {error_cnt, compares, cyc} = '0;
    RST = 1'b1;
    CMD_VALID = 1'b0;
    CMD = '0;
    last_q = 8'h00;
    t_reset();
    t_wr_rd();
    t_other_slot();
    t_refused();
    t_init();
    stop_test();
  end
endmodule
